// File: dpr_pkg.sv
package dpr_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int unsigned RAM_BYTES      = 2048;
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned BYTE_W         = 8;
  localparam int unsigned ADDR_W         = 16;
  localparam int unsigned WORDS          = RAM_BYTES / 2;
  localparam int unsigned IDX_W          = 10;
  localparam int unsigned IDX_LSB        = 1;
  localparam int unsigned IDX_MSB        = 10;
  localparam int unsigned BASE_MSB       = 15;
  localparam int unsigned BASE_LSB       = 11;
  localparam logic [4:0]  RAM_BASE_TAG   = 5'h0f;
  localparam logic [DATA_W-1:0] RST_DATA = 16'h0000;

  typedef logic [IDX_W-1:0] dpr_idx_type;
  typedef logic [DATA_W-1:0] dpr_word_type;
endpackage : dpr_pkg

// File: dpr_port_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dpr_port_if;
  import dpr_pkg::*;
  logic         we_a;
  logic [1:0]   be_a;
  dpr_idx_type  idx_a;
  dpr_word_type wd_a;
  logic         we_b;
  logic [1:0]   be_b;
  dpr_idx_type  idx_b;
  dpr_word_type wd_b;
  dpr_idx_type  ridx_a;
  dpr_idx_type  ridx_b;
  dpr_word_type rd_a;
  dpr_word_type rd_b;
  modport ctl (output we_a, be_a, idx_a, wd_a, we_b, be_b, idx_b, wd_b, ridx_a, ridx_b,
               input rd_a, rd_b);
  modport mem (input we_a, be_a, idx_a, wd_a, we_b, be_b, idx_b, wd_b, ridx_a, ridx_b,
               output rd_a, rd_b);
endinterface : dpr_port_if
`default_nettype wire

// File: dpr_array.sv
`timescale 1ns/100ps
`default_nettype none
module dpr_array
  import dpr_pkg::*;
(
  input  wire logic ref_clk,
  dpr_port_if.mem   p
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  dpr_word_type mem_reg  [WORDS];
  dpr_word_type mem_next [WORDS];
  dpr_word_type rd_a_reg;
  dpr_word_type rd_b_reg;

  always_comb begin
    for (int i = 0; i < WORDS; i++) begin
      mem_next[i] = mem_reg[i];
      for (int b = 0; b < 2; b++) begin
        if (p.we_b && p.be_b[b] && p.idx_b == dpr_idx_type'(i)) begin
          mem_next[i][b*BYTE_W +: BYTE_W] = p.wd_b[b*BYTE_W +: BYTE_W];
        end
        if (p.we_a && p.be_a[b] && p.idx_a == dpr_idx_type'(i)) begin
          mem_next[i][b*BYTE_W +: BYTE_W] = p.wd_a[b*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    mem_reg  <= mem_next;
    rd_a_reg <= mem_reg[p.ridx_a];
    rd_b_reg <= mem_reg[p.ridx_b];
  end

  assign p.rd_a = rd_a_reg;
  assign p.rd_b = rd_b_reg;
endmodule : dpr_array
`default_nettype wire

// File: dpr_ram.sv
// Notes on behaviour
// - 2-Kbyte dual-ported RAM at the top of implemented data space.
// - CPU and DMA accesses in one cycle are both served.
// - DMA access never takes cycles away from the CPU.
// - Same-location simultaneous writes: the CPU value is stored.
// - No stall is ever signalled to the CPU.
// - CPU byte write changes only the lane picked by address bit 0.
// - CPU word access at odd address inside the RAM window traps; misaligned write is dropped.
`timescale 1ns/100ps
`default_nettype none
module dpr_ram
  import dpr_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                srst,
  input  wire logic                cpu_req,
  input  wire logic                cpu_we,
  input  wire logic                cpu_byte,
  input  wire logic [ADDR_W-1:0]   cpu_addr,
  input  wire logic [DATA_W-1:0]   cpu_wdata,
  output logic      [DATA_W-1:0]   cpu_rdata,
  output logic                     cpu_hit,
  output logic                     cpu_stall,
  output logic                     cpu_addr_err,
  input  wire logic                dma_req,
  input  wire logic                dma_we,
  input  wire logic                dma_byte,
  input  wire logic [IDX_W:0]      dma_addr,
  input  wire logic [DATA_W-1:0]   dma_wdata,
  output logic      [DATA_W-1:0]   dma_rdata,
  output logic                     dma_ready
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  dpr_port_if pif ();

  function automatic logic [1:0] lane_sel(input logic is_byte, input logic a0);
    lane_sel = is_byte ? (a0 ? 2'h2 : 2'h1) : 2'h3;
  endfunction : lane_sel

  function automatic dpr_word_type lane_data(input logic is_byte, input logic a0,
                                             input dpr_word_type d);
    lane_data = (is_byte && a0) ? {d[BYTE_W-1:0], d[BYTE_W-1:0]} : d;
  endfunction : lane_data

  function automatic dpr_word_type lane_read(input logic is_byte, input logic a0,
                                             input dpr_word_type d);
    if (!is_byte) lane_read = d;
    else lane_read = a0 ? {8'h00, d[DATA_W-1:BYTE_W]} : {8'h00, d[BYTE_W-1:0]};
  endfunction : lane_read

  logic cpu_in_ram;
  logic cpu_misal;
  assign cpu_in_ram = cpu_addr[BASE_MSB:BASE_LSB] == RAM_BASE_TAG;
  assign cpu_misal  = !cpu_byte && cpu_addr[0];

  // ----------------------------------------
  // Port drive
  // ----------------------------------------
  assign pif.we_a   = cpu_req && cpu_we && cpu_in_ram && !cpu_misal;
  assign pif.be_a   = lane_sel(cpu_byte, cpu_addr[0]);
  assign pif.idx_a  = cpu_addr[IDX_MSB:IDX_LSB];
  assign pif.wd_a   = lane_data(cpu_byte, cpu_addr[0], cpu_wdata);
  assign pif.ridx_a = cpu_addr[IDX_MSB:IDX_LSB];
  assign pif.we_b   = dma_req && dma_we;
  assign pif.be_b   = lane_sel(dma_byte, dma_addr[0]);
  assign pif.idx_b  = dma_addr[IDX_W:1];
  assign pif.wd_b   = lane_data(dma_byte, dma_addr[0], dma_wdata);
  assign pif.ridx_b = dma_addr[IDX_W:1];

  dpr_array u_array (
    .ref_clk (ref_clk),
    .p       (pif.mem)
  );

  // ----------------------------------------
  // Read return and trap
  // ----------------------------------------
  logic cpu_rd_reg, cpu_rd_next;
  logic cpu_byte_reg, cpu_byte_next;
  logic cpu_a0_reg, cpu_a0_next;
  logic dma_rd_reg, dma_rd_next;
  logic dma_byte_reg, dma_byte_next;
  logic dma_a0_reg, dma_a0_next;
  logic err_reg, err_next;
  logic hit_reg, hit_next;
  dpr_word_type cpu_rdata_reg, cpu_rdata_next;
  dpr_word_type dma_rdata_reg, dma_rdata_next;

  always_comb begin
    cpu_rd_next    = cpu_req && !cpu_we && cpu_in_ram;
    cpu_byte_next  = cpu_byte;
    cpu_a0_next    = cpu_addr[0];
    dma_rd_next    = dma_req && !dma_we;
    dma_byte_next  = dma_byte;
    dma_a0_next    = dma_addr[0];
    err_next       = cpu_req && cpu_in_ram && cpu_misal;
    hit_next       = cpu_req && cpu_in_ram;
    cpu_rdata_next = cpu_rdata_reg;
    dma_rdata_next = dma_rdata_reg;
    if (cpu_rd_reg) begin
      cpu_rdata_next = lane_read(cpu_byte_reg, cpu_a0_reg, pif.rd_a);
    end
    if (dma_rd_reg) begin
      dma_rdata_next = lane_read(dma_byte_reg, dma_a0_reg, pif.rd_b);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cpu_rd_reg    <= 1'b0;
      cpu_byte_reg  <= 1'b0;
      cpu_a0_reg    <= 1'b0;
      dma_rd_reg    <= 1'b0;
      dma_byte_reg  <= 1'b0;
      dma_a0_reg    <= 1'b0;
      err_reg       <= 1'b0;
      hit_reg       <= 1'b0;
      cpu_rdata_reg <= RST_DATA;
      dma_rdata_reg <= RST_DATA;
    end else begin
      cpu_rd_reg    <= cpu_rd_next;
      cpu_byte_reg  <= cpu_byte_next;
      cpu_a0_reg    <= cpu_a0_next;
      dma_rd_reg    <= dma_rd_next;
      dma_byte_reg  <= dma_byte_next;
      dma_a0_reg    <= dma_a0_next;
      err_reg       <= err_next;
      hit_reg       <= hit_next;
      cpu_rdata_reg <= cpu_rdata_next;
      dma_rdata_reg <= dma_rdata_next;
    end
  end

  // cpu_rdata is a combinational view of the registered read so data lands 1 cycle after request
  assign cpu_rdata    = cpu_rd_reg ? lane_read(cpu_byte_reg, cpu_a0_reg, pif.rd_a) : cpu_rdata_reg;
  assign dma_rdata    = dma_rd_reg ? lane_read(dma_byte_reg, dma_a0_reg, pif.rd_b) : dma_rdata_reg;
  assign cpu_stall    = 1'b0;
  assign dma_ready    = 1'b1;
  assign cpu_addr_err = err_reg;
  assign cpu_hit      = hit_reg;
endmodule : dpr_ram
`default_nettype wire

// File: dpr_ram_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module dpr_ram_monitor
  import dpr_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              srst,
  input wire logic              cpu_req,
  input wire logic              cpu_we,
  input wire logic              cpu_byte,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic [DATA_W-1:0] cpu_wdata,
  input wire logic [DATA_W-1:0] cpu_rdata,
  input wire logic              cpu_hit,
  input wire logic              cpu_stall,
  input wire logic              cpu_addr_err,
  input wire logic              dma_req,
  input wire logic              dma_we,
  input wire logic              dma_byte,
  input wire logic [IDX_W:0]    dma_addr,
  input wire logic [DATA_W-1:0] dma_wdata,
  input wire logic [DATA_W-1:0] dma_rdata,
  input wire logic              dma_ready
);
  // ----
  // Checks
  // ----
  wire win = cpu_addr[15:11] == RAM_BASE_TAG;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  AST_STALL: assert property (!cpu_stall) else $error("stall seen");
  AST_READY: assert property (dma_ready) else $error("dma held off");
  AST_HIT: assert property (!$past(srst) |-> cpu_hit == $past(cpu_req && win))
    else $error("hit wrong");
  AST_AERR: assert property (!$past(srst) |->
    cpu_addr_err == $past(cpu_req && win && !cpu_byte && cpu_addr[0])) else $error("trap wrong");
  AST_ZEXT: assert property (cpu_req && win && !cpu_we && cpu_byte |=>
    cpu_rdata[15:8] == 8'h00) else $error("byte read not zero extended");
  AST_HOLD: assert property (!(cpu_req && win && !cpu_we) |=> $stable(cpu_rdata))
    else $error("read data moved");
  AST_CPU_WINS: assert property (cpu_req && cpu_we && !cpu_byte && win && !cpu_addr[0] &&
    dma_req && dma_we && !dma_byte && dma_addr[10:1] == cpu_addr[10:1] ##1
    !cpu_req && !(dma_req && dma_we) ##1 cpu_req && !cpu_we && !cpu_byte &&
    $stable(cpu_addr) |=> cpu_rdata == $past(cpu_wdata, 3)) else $error("cpu lost");
  AST_DMA_RW: assert property (dma_req && dma_we && !dma_byte && !(cpu_req && cpu_we) &&
    !dma_addr[0] ##1 !dma_req && !(cpu_req && cpu_we) ##1 dma_req && !dma_we &&
    $stable(dma_addr) |=> dma_rdata == $past(dma_wdata, 3)) else $error("dma data lost");
  cover property (cpu_req && dma_req);
  cover property (cpu_addr_err);
  cover property (cpu_req && cpu_byte && cpu_we);
endmodule : dpr_ram_monitor
bind dpr_ram dpr_ram_monitor mon_u (.ref_clk, .srst, .cpu_req, .cpu_we, .cpu_byte, .cpu_addr,
  .cpu_wdata, .cpu_rdata, .cpu_hit, .cpu_stall, .cpu_addr_err, .dma_req, .dma_we, .dma_byte,
  .dma_addr, .dma_wdata, .dma_rdata, .dma_ready);
`default_nettype wire

// File: dpr_dma_model.sv
`timescale 1ns/100ps
`default_nettype none
module dpr_dma_model
  import dpr_pkg::*;
(
  input  wire logic         ref_clk,
  output logic              req,
  output logic              we,
  output logic [IDX_W:0]    addr,
  output logic [DATA_W-1:0] wdata
);
  initial begin
    req = 1'b0;
    we = 1'b0;
    addr = '0;
    wdata = '0;
  end
  // ----
  // One transfer, released data flipped
  // ----
  task automatic op(input logic w, input logic [IDX_W:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    req <= 1'b1;
    we <= w;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    req <= 1'b0;
    wdata <= ~d;
  endtask : op
endmodule : dpr_dma_model
`default_nettype wire

// File: dpr_ram_bench.sv
`timescale 1ns/100ps
`default_nettype none
module dpr_ram_bench;
  import dpr_pkg::*;
  logic              ref_clk, srst, cpu_req, cpu_we, cpu_byte, cpu_hit, cpu_stall, cpu_addr_err;
  logic              dma_req, dma_we, dma_ready;
  logic [ADDR_W-1:0] cpu_addr;
  dpr_word_type      cpu_wdata, cpu_rdata, dma_wdata, dma_rdata;
  logic [IDX_W:0]    dma_addr;
  int                err_total, n_checks;
  dpr_ram dut_u (.ref_clk, .srst, .cpu_req, .cpu_we, .cpu_byte, .cpu_addr, .cpu_wdata, .cpu_rdata,
    .cpu_hit, .cpu_stall, .cpu_addr_err, .dma_req, .dma_we, .dma_byte(1'b0), .dma_addr,
    .dma_wdata, .dma_rdata, .dma_ready);
  dpr_dma_model dma_u (.ref_clk, .req(dma_req), .we(dma_we), .addr(dma_addr), .wdata(dma_wdata));
  always #5 ref_clk = ~ref_clk;
  // ----
  // Shared tasks
  // ----
  task automatic chk(input dpr_word_type got, input dpr_word_type exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cpu(input logic w, input logic b, input logic [ADDR_W-1:0] a, dpr_word_type d);
    @(posedge ref_clk);
    cpu_req <= 1'b1;
    cpu_we <= w;
    cpu_byte <= b;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge ref_clk);
    cpu_req <= 1'b0;
    cpu_wdata <= ~d;
    #1;
  endtask : cpu
  task automatic final_report;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // ----
  // Scenarios
  // ----
  task automatic s_plain;
    cpu(1'b1, 1'b0, 16'h7ffe, 16'hbeef);
    cpu(1'b0, 1'b0, 16'h7ffe, 16'h0000);
    chk(cpu_rdata, 16'hbeef);
    chk({15'h0000, cpu_hit}, 16'h0001);
    dma_u.op(1'b0, 11'h7fe, 16'h0000);
    #1;
    chk(dma_rdata, 16'hbeef);
    dma_u.op(1'b1, 11'h7fc, 16'h1357);
    dma_u.op(1'b0, 11'h7fc, 16'h0000);
    #1;
    chk(dma_rdata, 16'h1357);
    cpu(1'b1, 1'b0, 16'h7000, 16'h5555);
    chk({15'h0000, cpu_hit}, 16'h0000);
  endtask : s_plain
  task automatic s_both;
    fork
      cpu(1'b1, 1'b0, 16'h7802, 16'haaaa);
      dma_u.op(1'b1, 11'h002, 16'h5555);
    join
    fork
      cpu(1'b0, 1'b0, 16'h7802, 16'h0000);
      dma_u.op(0, 11'h002, 16'h0000);
    join
    chk(cpu_rdata, 16'haaaa);
    chk(dma_rdata, 16'haaaa);
    fork
      cpu(1'b1, 1'b0, 16'h7802, 16'h0f0f);
      dma_u.op(1'b0, 11'h002, 16'h0000);
    join
    chk(dma_rdata, 16'haaaa);
  endtask : s_both
  task automatic s_lane;
    cpu(1'b1, 1'b0, 16'h7804, 16'h1234);
    cpu(1'b1, 1'b1, 16'h7805, 16'h00ab);
    cpu(1'b0, 1'b0, 16'h7804, 16'h0000);
    chk(cpu_rdata, 16'hab34);
    cpu(1'b0, 1'b1, 16'h7805, 16'h0000);
    chk(cpu_rdata, 16'h00ab);
    cpu(1'b1, 1'b0, 16'h7806, 16'h2222);
    cpu(1'b1, 1'b0, 16'h7807, 16'hffff);
    chk({15'h0000, cpu_addr_err}, 16'h0001);
    cpu(1'b0, 1'b0, 16'h7806, 16'h0000);
    chk({15'h0000, cpu_addr_err}, 16'h0000);
    chk(cpu_rdata, 16'h2222);
  endtask : s_lane
  initial begin
    {ref_clk, cpu_req, cpu_we, cpu_byte, err_total, n_checks} = '0;
    srst = 1'b1;
    cpu_addr = '0;
    cpu_wdata = '0;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    s_plain();
    s_both();
    s_lane();
    final_report();
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    err_total++;
    final_report();
  end
endmodule : dpr_ram_bench
`default_nettype wire
